// [logic/rt_option_pkg.sv]
// Constants shared by the RT option configuration block and its holding memory.
// Assumes a 16-bit host register port and a word-wide engine interface.
package rt_option_pkg;
  // ==========================================================================
  // Register offsets on the host register port
  localparam logic [7:0] OFS_BUILTIN_TEST_WORD = 8'h1E;
  localparam logic [7:0] OFS_ALTERNATE_TEST_WORD = 8'h1F;
  localparam logic [7:0] OFS_RT_OPTION_CONFIG = 8'h20;
  // ==========================================================================
  // Option bit positions in rt_option_config
  localparam int BIT_BCST_SEPARATE = 8;
  localparam int BIT_SIMPLIFIED_MC = 7;
  localparam int BIT_HOLDING_BUF = 6;
  localparam int BIT_ALT_TEST_WORD = 5;
  // Device-owned bits of builtin_test_word
  localparam int BIT_LAST_MSG_ERROR = 15;
  localparam int BIT_RT_EXEC_SEEN = 14;
  localparam int BIT_COPY_BUSY = 13;
  localparam int HOST_BITS = 13;
  // ==========================================================================
  // Reset values and sizes
  localparam logic OPTION_RESET = 1'b0;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam int HOLD_WORDS = 32;
  localparam int IDX_W = 5;
  localparam int SA_W = 5;
  localparam int WORD_W = 16;
  localparam int BUF_ADDR_W = 1 + SA_W + IDX_W;
  localparam int BANK_BIT = BUF_ADDR_W - 1;
  // ==========================================================================
  // Holding buffer copy states
  typedef enum logic [1:0] {
    COPY_IDLE = 2'b01,
    COPY_RUN = 2'b10
  } copy_state_t;
endpackage : rt_option_pkg

// [logic/hold_word_mem.sv]
// Small holding memory for received data words of one message.
// Assumes one writer and one reader on the same clock; read data is registered.
`timescale 1ns/1ps
module hold_word_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic clock,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  // ==========================================================================
  // Storage
  logic [WIDTH-1:0] mem [DEPTH];

  // Write port
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read port
  always_ff @(posedge clock) begin
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule : hold_word_mem

// [logic/rt_option_config_bits.sv]
// RT option configuration bits: broadcast storage, mode processing, holding buffer
// and test word selection. Assumes the RT message engine on the same clock drives
// the rx, message and mode code strobes, and the host uses the register port.
//
// Summary of operation
// R1: Separate option puts broadcast data in own bank
// R2: Option clear shares broadcast and normal buffer
// R3: Simplified option selects simplified mode command processing
// R4: Holding option collects receive words in 32-word buffer
// R5: Held words copied only after error-free completion
// R6: Host changes holding option only while RT stopped; the write is accepted whatever rt_execution_enable is
// R7: Default selection answers test word at 0x001E
// R8: Alternate selection answers test word at 0x001F
// R9: Default word has device bits; alternate host-only
// R10: All option bits clear after reset
`timescale 1ns/1ps
module rt_option_config_bits
  import rt_option_pkg::*;
#(
  parameter int DEPTH = HOLD_WORDS
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata_q,
  input wire logic rt_execution_enable,
  input wire logic rx_word_valid,
  input wire logic [IDX_W-1:0] rx_word_index,
  input wire logic [SA_W-1:0] rx_subaddr,
  input wire logic rx_broadcast,
  input wire logic [15:0] rx_word_data,
  input wire logic msg_done,
  input wire logic msg_error,
  input wire logic bit_word_req,
  output logic broadcast_separate_store,
  output logic simplified_mode_cmd_en,
  output logic rx_holding_buffer_en,
  output logic alternate_test_word_sel,
  output logic copy_busy_q,
  output logic buf_wr_en_q,
  output logic [BUF_ADDR_W-1:0] buf_wr_addr_q,
  output logic [15:0] buf_wr_data_q,
  output logic bit_word_valid_q,
  output logic [15:0] bit_word_q
);
  // ==========================================================================
  // Declarations
  logic [HOST_BITS-1:0] bit_host_q;
  logic last_err_q;
  logic exec_seen_q;
  logic [15:0] alt_word_q;
  logic [15:0] builtin_word;
  logic [IDX_W:0] hold_cnt_q;
  logic hold_sa_bank_q;
  logic [SA_W-1:0] hold_sa_q;
  copy_state_t state_q;
  logic [IDX_W-1:0] rd_idx_q;
  logic [IDX_W-1:0] copy_idx_q;
  logic copy_pipe_q;
  logic [15:0] hold_rdata;
  logic hold_wr;
  logic copy_go;
  logic [IDX_W:0] copy_cnt_q;

  // Bank select for a broadcast word
  function automatic logic bank_of(input logic bcst, input logic sep);
    return bcst & sep;
  endfunction : bank_of

  // Register decode helper
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction : hit

  // Last index of the held message, latched count minus one
  function automatic logic [IDX_W:0] hold_cnt_copy_last();
    return copy_cnt_q - (IDX_W + 1)'(1);
  endfunction : hold_cnt_copy_last

  // ==========================================================================
  // Option register, cleared by reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      broadcast_separate_store <= OPTION_RESET; // R10
      simplified_mode_cmd_en <= OPTION_RESET; // R10
      rx_holding_buffer_en <= OPTION_RESET; // R10
      alternate_test_word_sel <= OPTION_RESET; // R10
    end else if (reg_wr && hit(reg_addr, OFS_RT_OPTION_CONFIG)) begin
      broadcast_separate_store <= reg_wdata[BIT_BCST_SEPARATE];
      simplified_mode_cmd_en <= reg_wdata[BIT_SIMPLIFIED_MC]; // R3
      // Changing this with the RT running is undefined; software keeps it stopped
      rx_holding_buffer_en <= reg_wdata[BIT_HOLDING_BUF]; // R6
      alternate_test_word_sel <= reg_wdata[BIT_ALT_TEST_WORD];
    end
  end

  // Test word registers; device owns the top bits of the default word
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bit_host_q <= WORD_RESET[HOST_BITS-1:0];
      alt_word_q <= WORD_RESET;
    end else if (reg_wr) begin
      if (hit(reg_addr, OFS_BUILTIN_TEST_WORD)) begin
        bit_host_q <= reg_wdata[HOST_BITS-1:0]; // R9
      end
      if (hit(reg_addr, OFS_ALTERNATE_TEST_WORD)) begin
        alt_word_q <= reg_wdata; // R9
      end
    end
  end

  // Device status bits of the default test word
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      last_err_q <= 1'b0;
      exec_seen_q <= 1'b0;
    end else begin
      exec_seen_q <= rt_execution_enable;
      if (msg_done) begin
        last_err_q <= msg_error;
      end
    end
  end

  assign builtin_word = {last_err_q, exec_seen_q, copy_busy_q, bit_host_q}; // R9

  // Host read port, one cycle latency, unmapped reads zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata_q <= WORD_RESET;
    end else if (reg_rd) begin
      unique case (reg_addr)
        OFS_BUILTIN_TEST_WORD: reg_rdata_q <= builtin_word;
        OFS_ALTERNATE_TEST_WORD: reg_rdata_q <= alt_word_q;
        OFS_RT_OPTION_CONFIG: begin
          reg_rdata_q <= WORD_RESET;
          reg_rdata_q[BIT_BCST_SEPARATE] <= broadcast_separate_store;
          reg_rdata_q[BIT_SIMPLIFIED_MC] <= simplified_mode_cmd_en;
          reg_rdata_q[BIT_HOLDING_BUF] <= rx_holding_buffer_en;
          reg_rdata_q[BIT_ALT_TEST_WORD] <= alternate_test_word_sel;
        end
        default: reg_rdata_q <= WORD_RESET;
      endcase
    end
  end

  // ==========================================================================
  // Transmit BIT word answer, selected by the alternate option
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bit_word_valid_q <= 1'b0;
      bit_word_q <= WORD_RESET;
    end else begin
      bit_word_valid_q <= bit_word_req;
      if (bit_word_req) begin
        bit_word_q <= alternate_test_word_sel ? alt_word_q : builtin_word; // R7 R8
      end
    end
  end

  // ==========================================================================
  // Holding buffer fill and count
  assign hold_wr = rx_word_valid && rx_holding_buffer_en; // R4
  assign copy_go = msg_done && !msg_error && rx_holding_buffer_en
    && (hold_cnt_q != '0) && (state_q == COPY_IDLE); // R5

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hold_cnt_q <= '0;
      hold_sa_q <= '0;
      hold_sa_bank_q <= 1'b0;
    end else if (msg_done) begin
      hold_cnt_q <= '0; // Erroneous message words are dropped here
    end else if (hold_wr) begin
      hold_cnt_q <= {1'b0, rx_word_index} + (IDX_W + 1)'(1); // R4
      hold_sa_q <= rx_subaddr;
      hold_sa_bank_q <= bank_of(rx_broadcast, broadcast_separate_store);
    end
  end

  hold_word_mem #(
    .WIDTH(WORD_W),
    .DEPTH(DEPTH),
    .AW(IDX_W)
  ) u_hold (
    .clock(clock),
    .wr_en(hold_wr),
    .wr_addr(rx_word_index),
    .wr_data(rx_word_data),
    .rd_en(state_q == COPY_RUN),
    .rd_addr(rd_idx_q),
    .rd_data(hold_rdata)
  );

  // Copy engine: drain held words into the subaddress buffer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= COPY_IDLE;
      rd_idx_q <= '0;
      copy_busy_q <= 1'b0;
    end else begin
      unique case (state_q)
        COPY_IDLE: begin
          rd_idx_q <= '0;
          if (copy_go) begin
            state_q <= COPY_RUN; // R5
            copy_busy_q <= 1'b1;
          end else begin
            copy_busy_q <= copy_pipe_q;
          end
        end
        COPY_RUN: begin
          rd_idx_q <= rd_idx_q + IDX_W'(1);
          if ({1'b0, rd_idx_q} == hold_cnt_copy_last()) begin
            state_q <= COPY_IDLE;
          end
        end
      endcase
    end
  end

  // Latched count, copy pipeline flag and index of the word being written
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      copy_cnt_q <= '0;
      copy_pipe_q <= 1'b0;
      copy_idx_q <= '0;
    end else begin
      if (copy_go) begin
        copy_cnt_q <= hold_cnt_q;
      end
      copy_pipe_q <= (state_q == COPY_RUN);
      copy_idx_q <= rd_idx_q;
    end
  end

  // ==========================================================================
  // Buffer write port: direct words or copied held words
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      buf_wr_en_q <= 1'b0;
      buf_wr_addr_q <= '0;
      buf_wr_data_q <= WORD_RESET;
    end else if (copy_pipe_q) begin
      buf_wr_en_q <= 1'b1; // R5
      buf_wr_addr_q <= {hold_sa_bank_q, hold_sa_q, copy_idx_q};
      buf_wr_data_q <= hold_rdata;
    end else if (rx_word_valid && !rx_holding_buffer_en) begin
      buf_wr_en_q <= 1'b1;
      buf_wr_addr_q <= {bank_of(rx_broadcast, broadcast_separate_store), // R1 R2
        rx_subaddr, rx_word_index};
      buf_wr_data_q <= rx_word_data;
    end else begin
      buf_wr_en_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Checks
  sequence s_good_end;
    msg_done && !msg_error && rx_holding_buffer_en && hold_cnt_q != '0
      && state_q == COPY_IDLE && !copy_pipe_q;
  endsequence

  sequence s_bad_end;
    msg_done && msg_error && state_q == COPY_IDLE && !copy_pipe_q;
  endsequence

  a_bcst_sep_bank: assert property (@(posedge clock) disable iff (rst) // R1
    rx_word_valid && !rx_holding_buffer_en && !copy_pipe_q && broadcast_separate_store
    |=> buf_wr_en_q && buf_wr_addr_q[BANK_BIT] == $past(rx_broadcast))
    else $error("broadcast word not in separate bank");
  a_bcst_shared_bank: assert property (@(posedge clock) disable iff (rst) // R2
    rx_word_valid && !rx_holding_buffer_en && !copy_pipe_q && !broadcast_separate_store
    |=> buf_wr_en_q && !buf_wr_addr_q[BANK_BIT])
    else $error("shared broadcast word in wrong bank");
  a_simplified_set: assert property (@(posedge clock) disable iff (rst) // R3
    reg_wr && reg_addr == OFS_RT_OPTION_CONFIG
    |=> simplified_mode_cmd_en == $past(reg_wdata[BIT_SIMPLIFIED_MC]))
    else $error("simplified mode option not stored");
  a_hold_no_write: assert property (@(posedge clock) disable iff (rst) // R4
    hold_wr && state_q == COPY_IDLE && !copy_pipe_q |=> !buf_wr_en_q)
    else $error("held word written straight to buffer");
  a_copy_starts: assert property (@(posedge clock) disable iff (rst) // R5
    s_good_end |=> ##2 buf_wr_en_q ##0 copy_busy_q)
    else $error("held words not copied after good message");
  a_error_discard: assert property (@(posedge clock) disable iff (rst) // R5
    s_bad_end ##0 rx_holding_buffer_en |=> state_q == COPY_IDLE && !copy_busy_q)
    else $error("errored message reached the buffer");
  a_default_word: assert property (@(posedge clock) disable iff (rst) // R7
    bit_word_req && !alternate_test_word_sel
    |=> bit_word_valid_q && bit_word_q == $past(builtin_word))
    else $error("default test word not answered");
  a_alt_word: assert property (@(posedge clock) disable iff (rst) // R8
    bit_word_req && alternate_test_word_sel
    |=> bit_word_valid_q && bit_word_q == $past(alt_word_q))
    else $error("alternate test word not answered");
  a_device_bits: assert property (@(posedge clock) disable iff (rst) // R9
    reg_wr && reg_addr == OFS_BUILTIN_TEST_WORD && !msg_done
    |=> last_err_q == $past(last_err_q))
    else $error("host write changed device status bit");
endmodule : rt_option_config_bits

// [dv/rt_engine_model.sv]
// Behavioural model of the RT message engine and bus traffic feeding the option block.
// Assumes the bench calls its tasks just after a rising clock edge.
`timescale 1ns/1ps
module rt_engine_model
  import rt_option_pkg::*;
(
  input wire logic clock,
  output logic rx_word_valid,
  output logic [IDX_W-1:0] rx_word_index,
  output logic [SA_W-1:0] rx_subaddr,
  output logic rx_broadcast,
  output logic [15:0] rx_word_data,
  output logic msg_done,
  output logic msg_error,
  output logic bit_word_req
);
  // ====================
  // Idle levels
  initial begin
    {rx_word_valid, rx_broadcast, msg_done, msg_error, bit_word_req} = 5'h00;
    rx_word_index = '0;
    rx_subaddr = '0;
    rx_word_data = 16'h0000;
  end
  task automatic tick();
    @(posedge clock);
    #1;
  endtask : tick
  // ====================
  // One received data word, held for one edge
  task automatic word(input logic [SA_W-1:0] sa, input logic bc, input logic [IDX_W-1:0] idx,
                      input logic [15:0] d);
    rx_word_valid = 1'b1;
    rx_subaddr = sa;
    rx_broadcast = bc;
    rx_word_index = idx;
    rx_word_data = d;
    tick();
    rx_word_valid = 1'b0;
    rx_word_data = ~d; // Released data line shows no stale word
    tick(); // Idle edge so a following word raises the strobe afresh
  endtask : word
  // End of message, with or without error
  task automatic done(input logic err);
    msg_done = 1'b1;
    msg_error = err;
    tick();
    msg_done = 1'b0;
    msg_error = ~err;
  endtask : done
  // Transmit BIT word mode command
  task automatic bitreq();
    bit_word_req = 1'b1;
    tick();
    bit_word_req = 1'b0;
  endtask : bitreq
endmodule : rt_engine_model

// [dv/rt_option_config_bits_tb.sv]
// Self-checking bench for the RT option configuration bits.
// Assumes the engine model drives the receive strobes; the bench acts as host.
`timescale 1ns/1ps
module rt_option_config_bits_tb;
  import rt_option_pkg::*;
  typedef struct {logic [7:0] a; logic [15:0] w; logic [15:0] r; logic [3:0] o;} row_t;
  logic clock, rst, reg_wr, reg_rd, rt_execution_enable;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata_q, rx_word_data, buf_wr_data_q, bit_word_q;
  logic rx_word_valid, rx_broadcast, msg_done, msg_error, bit_word_req;
  logic [IDX_W-1:0] rx_word_index;
  logic [SA_W-1:0] rx_subaddr;
  logic bsep, smode, hold, alt, copy_busy_q, buf_wr_en_q, bit_word_valid_q;
  logic [BUF_ADDR_W-1:0] buf_wr_addr_q;
  logic [31:0] seen[$];
  logic [31:0] exp_q[$];
  int failures, check_count;
  row_t rows[5] = '{
    '{8'h1F, 16'hFFFF, 16'hFFFF, 4'h0},
    '{8'h1E, 16'hFFFF, 16'h1FFF, 4'h0},
    '{8'h20, 16'hFFFF, 16'h01E0, 4'hF},
    '{8'h20, 16'h0000, 16'h0000, 4'h0},
    '{8'h21, 16'hFFFF, 16'h0000, 4'h0}};
  // ====================
  // Design, engine model and clock
  rt_option_config_bits rt_option_config_bits_i (.clock(clock), .rst(rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .rt_execution_enable(rt_execution_enable), .rx_word_valid(rx_word_valid),
    .rx_word_index(rx_word_index), .rx_subaddr(rx_subaddr), .rx_broadcast(rx_broadcast),
    .rx_word_data(rx_word_data), .msg_done(msg_done), .msg_error(msg_error),
    .bit_word_req(bit_word_req), .broadcast_separate_store(bsep),
    .simplified_mode_cmd_en(smode), .rx_holding_buffer_en(hold),
    .alternate_test_word_sel(alt), .copy_busy_q(copy_busy_q), .buf_wr_en_q(buf_wr_en_q),
    .buf_wr_addr_q(buf_wr_addr_q), .buf_wr_data_q(buf_wr_data_q),
    .bit_word_valid_q(bit_word_valid_q), .bit_word_q(bit_word_q));
  rt_engine_model rt_engine_model_i (.clock(clock), .rx_word_valid(rx_word_valid),
    .rx_word_index(rx_word_index), .rx_subaddr(rx_subaddr), .rx_broadcast(rx_broadcast),
    .rx_word_data(rx_word_data), .msg_done(msg_done), .msg_error(msg_error),
    .bit_word_req(bit_word_req));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Capture every buffer write as {address, data}
  always @(posedge clock) begin
    if (buf_wr_en_q === 1'b1) seen.push_back({5'h00, buf_wr_addr_q, buf_wr_data_q});
  end
  // ====================
  // Helpers
  task automatic tick();
    @(posedge clock);
    #1;
  endtask : tick
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    tick();
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    reg_rd = 1'b1;
    reg_addr = a;
    tick();
    reg_rd = 1'b0;
    chk("reg_rdata", {16'h0000, e}, {16'h0000, reg_rdata_q});
  endtask : rd_chk
  task automatic put(input logic b, input logic [4:0] sa, input logic [4:0] i, input logic [15:0] d);
    exp_q.push_back({5'h00, b, sa, i, d});
  endtask : put
  // Compare captured buffer writes with the expected list, then clear both
  task automatic cmp_writes();
    for (int k = 0; k < 64 && copy_busy_q !== 1'b0; k++) tick();
    if (copy_busy_q !== 1'b0) begin
      failures++;
      report_and_stop();
    end
    repeat (4) tick();
    chk("write_count", exp_q.size(), seen.size());
    for (int k = 0; k < exp_q.size() && k < seen.size(); k++) chk("buf_write", exp_q[k], seen[k]);
    seen.delete();
    exp_q.delete();
  endtask : cmp_writes
  task automatic bit_chk(input logic [15:0] e);
    rt_engine_model_i.bitreq();
    chk("bit_word_valid", 32'h1, {31'h0, bit_word_valid_q});
    chk("bit_word", {16'h0000, e}, {16'h0000, bit_word_q});
  endtask : bit_chk
  // ====================
  // Main sequence
  initial begin
    {rst, reg_wr, reg_rd, rt_execution_enable} = 4'h8;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    repeat (8) tick();
    rst = 1'b0;
    chk("options_reset", 32'h0, {28'h0, bsep, smode, hold, alt});
    rd_chk(OFS_RT_OPTION_CONFIG, 16'h0000);
    // Register rows: write, read back, option levels
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd_chk(rows[i].a, rows[i].r);
      chk("options", {28'h0, rows[i].o}, {28'h0, bsep, smode, hold, alt});
    end
    $display("test registers done");
    // Direct stores: shared, then separated broadcast bank
    rt_engine_model_i.word(5'd3, 1'b1, 5'd2, 16'hA5A5);
    put(1'b0, 5'd3, 5'd2, 16'hA5A5);
    cmp_writes();
    wr(OFS_RT_OPTION_CONFIG, 16'h0100);
    rt_engine_model_i.word(5'd3, 1'b1, 5'd2, 16'h5A5A);
    rt_engine_model_i.word(5'd3, 1'b0, 5'd4, 16'h1234);
    put(1'b1, 5'd3, 5'd2, 16'h5A5A);
    put(1'b0, 5'd3, 5'd4, 16'h1234);
    cmp_writes();
    $display("test broadcast done");
    // Holding buffer: erroneous message writes nothing, good one is copied
    wr(OFS_RT_OPTION_CONFIG, 16'h0040);
    for (int i = 0; i < 3; i++) rt_engine_model_i.word(5'd7, 1'b0, 5'(i), 16'h1000 + 16'(i));
    rt_engine_model_i.done(1'b1);
    cmp_writes();
    bit_chk(16'h9FFF);
    for (int i = 0; i < 3; i++) rt_engine_model_i.word(5'd7, 1'b0, 5'(i), 16'h2000 + 16'(i));
    rt_engine_model_i.done(1'b0);
    chk("copy_busy", 32'h1, {31'h0, copy_busy_q});
    for (int i = 0; i < 3; i++) put(1'b0, 5'd7, 5'(i), 16'h2000 + 16'(i));
    cmp_writes();
    $display("test holding done");
    // Test word selection
    wr(OFS_RT_OPTION_CONFIG, 16'h0020);
    rt_execution_enable = 1'b1;
    tick();
    bit_chk(16'hFFFF);
    wr(OFS_RT_OPTION_CONFIG, 16'h0000);
    bit_chk(16'h5FFF);
    $display("test bit word done");
    // Reset in mid-run clears every option
    rt_execution_enable = 1'b0;
    wr(OFS_RT_OPTION_CONFIG, 16'h01E0);
    chk("options_set", 32'hF, {28'h0, bsep, smode, hold, alt});
    rst = 1'b1;
    tick();
    chk("options_rst", 32'h0, {28'h0, bsep, smode, hold, alt});
    rst = 1'b0;
    rd_chk(OFS_RT_OPTION_CONFIG, 16'h0000);
    $display("test reset done");
    report_and_stop();
  end
endmodule : rt_option_config_bits_tb
